// [rtl/cqts_defines.svh]
`ifndef CQTS_DEFINES_SVH
`define CQTS_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CQTS_ADDR_W 8
`define CQTS_OFS_TRIG_CFG 8'h00
`define CQTS_OFS_TRIG_LEVEL 8'h04
`define CQTS_OFS_TRQ_SRC 8'h08
`define CQTS_OFS_TRQ_OFFSET 8'h0C
`define CQTS_OFS_TRQ_SCALE 8'h10
`define CQTS_OFS_SCALE_EN 8'h14
`define CQTS_OFS_GROUP_MAP 8'h18
`define CQTS_OFS_WIRING 8'h1C
`define CQTS_OFS_VSCALE0 8'h20
`define CQTS_OFS_CMD 8'h40
`define CQTS_OFS_RESP_FIELDS 8'h44
`define CQTS_OFS_RESP_VALUE 8'h48
`define CQTS_OFS_STATUS 8'h4C
`define CQTS_OFS_IRQ_STS 8'h50
`define CQTS_OFS_IRQ_MASK 8'h54

// ----------------------------------------------------------------
// sizes, field positions, codes
// ----------------------------------------------------------------
`define CQTS_NUM_CH 4
`define CQTS_NUM_GRP 3
`define CQTS_TRIG_METHOD_LSB 4
`define CQTS_TRIG_POS_LSB 8
`define CQTS_CMD_IDX_LSB 4
`define CQTS_TRIG_POS_BAD 2'h2
`define CQTS_TRQ_SRC_MAX 2'h2
`define CQTS_WIRING_MAX 3'h4
`define CQTS_NUM_IRQ 5
`define CQTS_IRQ_SAVE 0
`define CQTS_IRQ_LOAD 1
`define CQTS_IRQ_LOAD_ERR 2
`define CQTS_IRQ_QUERY 3
`define CQTS_IRQ_CMD_ERR 4

`endif

// [rtl/cqts_pkg.sv]
package cqts_pkg;

    // ----------------------------------------------------------------
    // command opcodes
    // ----------------------------------------------------------------
    typedef enum logic [3:0]
    {
        CQTS_OP_NONE = 4'h0,
        CQTS_OP_SAVE = 4'h1,
        CQTS_OP_LOAD = 4'h2,
        CQTS_OP_Q_TRIG = 4'h3,
        CQTS_OP_Q_TRQ_SRC = 4'h4,
        CQTS_OP_Q_TRQ_OFF = 4'h5,
        CQTS_OP_Q_TRQ_SCALE = 4'h6,
        CQTS_OP_Q_VOLTAGE_SCALING_QUERY = 4'h7,
        CQTS_OP_Q_GROUP = 4'h8,
        CQTS_OP_Q_WIRING = 4'h9
    } cqts_op_t;

    // ----------------------------------------------------------------
    // complete configuration, copied whole into the snapshot
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [2:0] trig_input;
        logic [1:0] trig_method;
        logic [1:0] trig_pos;
        logic [31:0] trig_level;
        logic [1:0] trq_src;
        logic [31:0] trq_offset;
        logic [31:0] trq_scale;
        logic [3:0] scale_en;
        logic [3:0][31:0] voltage_scaling_query;
        logic [3:0][1:0] group;
        logic [2:0][2:0] wiring;
    } cqts_cfg_t;

endpackage

// [rtl/cqts_top.sv]
`timescale 1ns/1ps
`include "cqts_defines.svh"
// Notes on behaviour
// R1 - the trigger query returns input, method, position and level, inputs coded 0 to 7.
// R2 - trigger method codes are 0 dc rising, 1 dc falling, 2 rectified rising, 3 high frequency.
// R3 - trigger position codes are 0 for 0%, 1 for 50% and 3 for 75% of the span.
// R4 - the trigger level is returned as a real value in volts or amperes.
// R5 - the torque source query returns 0 none, 1 analog or 2 digital.
// R6 - torque offset and torque scaling are returned by separate queries as reals.
// R7 - the voltage scaling query returns the channel factor, or 0.0 when scaling is off.
// R8 - the group query returns group 1 to 3, or 0 when unassigned or not installed.
// R9 - the wiring query returns a code 0 to 4 for the given group.
// R10 - a save copies the whole configuration into a volatile store.
// R11 - a load restores the store and raises an error when no save came before.
// R12 - each save allows exactly one load; a second load without a save is invalid.
// R13 - a valid flag is set by save, cleared by load or reset, and decides load errors.
module cqts_top #(
    parameter logic [3:0] CH_INSTALLED = 4'hF
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq
);
    import cqts_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cqts_cfg_t cfg_q, cfg_d, snap_q, snap_d;
    logic valid_q, valid_d;
    logic [31:0] fields_q, fields_d, value_q, value_d;
    logic [`CQTS_NUM_IRQ-1:0] sts_q, sts_d, mask_q, mask_d, ev;
    logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
    logic [31:0] prdata_q, prdata_d, rd_mux;
    logic done, wr, cmd_go, hit;
    cqts_op_t op;
    logic [3:0] idx;

    // 1-based channel identifier within range
    function automatic logic ch_ok(input logic [3:0] i);
        ch_ok = (i >= 4'h1) && (i <= 4'(`CQTS_NUM_CH));
    endfunction

    // 1-based group identifier within range
    function automatic logic grp_ok(input logic [3:0] i);
        grp_ok = (i >= 4'h1) && (i <= 4'(`CQTS_NUM_GRP));
    endfunction

    assign done = psel & penable & pready_q;
    assign wr = done & pwrite & ~pslverr_q;
    assign op = cqts_op_t'(pwdata[3:0]);
    assign idx = pwdata[`CQTS_CMD_IDX_LSB +: 4];
    assign cmd_go = wr & (paddr == `CQTS_OFS_CMD);

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_mux = 32'h0;
        hit = 1'b1;
        case (paddr)
            `CQTS_OFS_TRIG_CFG:
            begin
                rd_mux[2:0] = cfg_q.trig_input;
                rd_mux[`CQTS_TRIG_METHOD_LSB +: 2] = cfg_q.trig_method;
                rd_mux[`CQTS_TRIG_POS_LSB +: 2] = cfg_q.trig_pos;
            end
            `CQTS_OFS_TRIG_LEVEL: rd_mux = cfg_q.trig_level;
            `CQTS_OFS_TRQ_SRC: rd_mux[1:0] = cfg_q.trq_src;
            `CQTS_OFS_TRQ_OFFSET: rd_mux = cfg_q.trq_offset;
            `CQTS_OFS_TRQ_SCALE: rd_mux = cfg_q.trq_scale;
            `CQTS_OFS_SCALE_EN: rd_mux[3:0] = cfg_q.scale_en;
            `CQTS_OFS_GROUP_MAP: rd_mux[7:0] = cfg_q.group;
            `CQTS_OFS_WIRING: rd_mux[8:0] = cfg_q.wiring;
            `CQTS_OFS_CMD: rd_mux = 32'h0;
            `CQTS_OFS_RESP_FIELDS: rd_mux = fields_q;
            `CQTS_OFS_RESP_VALUE: rd_mux = value_q;
            `CQTS_OFS_STATUS: rd_mux[0] = valid_q;
            `CQTS_OFS_IRQ_STS: rd_mux[`CQTS_NUM_IRQ-1:0] = sts_q;
            `CQTS_OFS_IRQ_MASK: rd_mux[`CQTS_NUM_IRQ-1:0] = mask_q;
            default:
            begin
                // widened compare: a 2-bit channel count would wrap to zero
                if (paddr[7:4] == 4'h2 && paddr[1:0] == 2'h0
                    && {1'b0, paddr[3:2]} < 3'(`CQTS_NUM_CH))
                    rd_mux = cfg_q.voltage_scaling_query[paddr[3:2]];
                else
                    hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // apb handshake: one wait state, answer registered
    // ----------------------------------------------------------------
    always_comb
    begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (psel & penable & ~pready_q)
        begin
            pready_d = 1'b1;
            pslverr_d = ~hit;
            prdata_d = pwrite ? 32'h0 : rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // configuration writes and commands
    // ----------------------------------------------------------------
    always_comb
    begin
        cfg_d = cfg_q;
        snap_d = snap_q;
        valid_d = valid_q;
        fields_d = fields_q;
        value_d = value_q;
        mask_d = mask_q;
        ev = '0;
        if (wr)
        begin
            case (paddr)
                `CQTS_OFS_TRIG_CFG:
                begin
                    // position code 2 has no meaning, so the whole write is refused
                    if (pwdata[`CQTS_TRIG_POS_LSB +: 2] == `CQTS_TRIG_POS_BAD) // [R3]
                        ev[`CQTS_IRQ_CMD_ERR] = 1'b1;
                    else
                    begin
                        cfg_d.trig_input = pwdata[2:0]; // [R1]
                        cfg_d.trig_method = pwdata[`CQTS_TRIG_METHOD_LSB +: 2]; // [R2]
                        cfg_d.trig_pos = pwdata[`CQTS_TRIG_POS_LSB +: 2]; // [R3]
                    end
                end
                `CQTS_OFS_TRIG_LEVEL: cfg_d.trig_level = pwdata; // [R4]
                `CQTS_OFS_TRQ_SRC:
                begin
                    if (pwdata[1:0] > `CQTS_TRQ_SRC_MAX) // [R5]
                        ev[`CQTS_IRQ_CMD_ERR] = 1'b1;
                    else
                        cfg_d.trq_src = pwdata[1:0];
                end
                `CQTS_OFS_TRQ_OFFSET: cfg_d.trq_offset = pwdata; // [R6]
                `CQTS_OFS_TRQ_SCALE: cfg_d.trq_scale = pwdata; // [R6]
                `CQTS_OFS_SCALE_EN: cfg_d.scale_en = pwdata[3:0]; // [R7]
                `CQTS_OFS_GROUP_MAP:
                begin
                    // channels that are not fitted never join a group
                    for (int c = 0; c < `CQTS_NUM_CH; c++)
                        cfg_d.group[c] = CH_INSTALLED[c] ? pwdata[2*c +: 2] : 2'h0; // [R8]
                end
                `CQTS_OFS_WIRING:
                begin
                    cfg_d.wiring = pwdata[8:0];
                    for (int g = 0; g < `CQTS_NUM_GRP; g++)
                        if (pwdata[3*g +: 3] > `CQTS_WIRING_MAX) // [R9]
                        begin
                            cfg_d.wiring = cfg_q.wiring;
                            ev[`CQTS_IRQ_CMD_ERR] = 1'b1;
                        end
                end
                `CQTS_OFS_IRQ_MASK: mask_d = pwdata[`CQTS_NUM_IRQ-1:0];
                default:
                begin
                    if (paddr[7:4] == 4'h2)
                        cfg_d.voltage_scaling_query[paddr[3:2]] = pwdata; // [R7]
                end
            endcase
        end
        if (cmd_go)
        begin
            case (op)
                CQTS_OP_SAVE:
                begin
                    snap_d = cfg_q; // [R10]
                    valid_d = 1'b1; // [R13]
                    ev[`CQTS_IRQ_SAVE] = 1'b1;
                end
                CQTS_OP_LOAD:
                begin
                    // one load per save; the flag decides
                    if (valid_q) // [R11] [R12] [R13]
                    begin
                        cfg_d = snap_q;
                        valid_d = 1'b0;
                        ev[`CQTS_IRQ_LOAD] = 1'b1;
                    end
                    else
                        ev[`CQTS_IRQ_LOAD_ERR] = 1'b1;
                end
                CQTS_OP_Q_TRIG:
                begin
                    fields_d = {22'h0, cfg_q.trig_pos, 2'h0, cfg_q.trig_method,
                                1'b0, cfg_q.trig_input}; // [R1]
                    value_d = cfg_q.trig_level; // [R4]
                    ev[`CQTS_IRQ_QUERY] = 1'b1;
                end
                CQTS_OP_Q_TRQ_SRC:
                begin
                    fields_d = {30'h0, cfg_q.trq_src}; // [R5]
                    ev[`CQTS_IRQ_QUERY] = 1'b1;
                end
                CQTS_OP_Q_TRQ_OFF:
                begin
                    value_d = cfg_q.trq_offset; // [R6]
                    ev[`CQTS_IRQ_QUERY] = 1'b1;
                end
                CQTS_OP_Q_TRQ_SCALE:
                begin
                    value_d = cfg_q.trq_scale; // [R6]
                    ev[`CQTS_IRQ_QUERY] = 1'b1;
                end
                CQTS_OP_Q_VOLTAGE_SCALING_QUERY:
                begin
                    if (ch_ok(idx))
                    begin
                        value_d = cfg_q.scale_en[2'(idx - 4'h1)] ?
                                  cfg_q.voltage_scaling_query[2'(idx - 4'h1)] : 32'h0; // [R7]
                        ev[`CQTS_IRQ_QUERY] = 1'b1;
                    end
                    else
                        ev[`CQTS_IRQ_CMD_ERR] = 1'b1;
                end
                CQTS_OP_Q_GROUP:
                begin
                    if (ch_ok(idx))
                    begin
                        fields_d = {30'h0, CH_INSTALLED[2'(idx - 4'h1)] ?
                                    cfg_q.group[2'(idx - 4'h1)] : 2'h0}; // [R8]
                        ev[`CQTS_IRQ_QUERY] = 1'b1;
                    end
                    else
                        ev[`CQTS_IRQ_CMD_ERR] = 1'b1;
                end
                CQTS_OP_Q_WIRING:
                begin
                    if (grp_ok(idx))
                    begin
                        fields_d = {29'h0, cfg_q.wiring[2'(idx - 4'h1)]}; // [R9]
                        ev[`CQTS_IRQ_QUERY] = 1'b1;
                    end
                    else
                        ev[`CQTS_IRQ_CMD_ERR] = 1'b1;
                end
                default: ev[`CQTS_IRQ_CMD_ERR] = 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt status: read clears, a new event in that cycle wins
    // ----------------------------------------------------------------
    always_comb
    begin
        sts_d = sts_q;
        if (done & ~pwrite & (paddr == `CQTS_OFS_IRQ_STS))
            sts_d = '0;
        sts_d = sts_d | ev;
        irq_d = |(sts_d & mask_d);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= '0;
            snap_q <= '0;
            valid_q <= 1'b0; // [R13]
            fields_q <= 32'h0;
            value_q <= 32'h0;
            sts_q <= '0;
            mask_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            cfg_q <= cfg_d;
            snap_q <= snap_d;
            valid_q <= valid_d;
            fields_q <= fields_d;
            value_q <= value_d;
            sts_q <= sts_d;
            mask_q <= mask_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            irq_q <= irq_d;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;
    assign irq = irq_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_cmd(logic [3:0] code);
        cmd_go && pwdata[3:0] == code;
    endsequence

    a_load_no_save: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        s_cmd(4'h2) and !valid_q |=> sts_q[`CQTS_IRQ_LOAD_ERR] && cfg_q == $past(cfg_q))
        else $error("load without save did not flag an error");

    a_load_once_only: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        s_cmd(4'h2) and valid_q |=> !valid_q)
        else $error("snapshot still valid after a load");

    a_valid_needs_save: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !valid_q && !(cmd_go && pwdata[3:0] == 4'h1) |=> !valid_q)
        else $error("snapshot became valid without a save");

    a_save_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        s_cmd(4'h1) |=> valid_q && sts_q[`CQTS_IRQ_SAVE])
        else $error("save did not mark the snapshot valid");

    a_save_copies_cfg: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        s_cmd(4'h1) |=> snap_q == $past(cfg_q))
        else $error("snapshot differs from configuration at save");

    a_load_restores_cfg: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        s_cmd(4'h2) and valid_q |=> cfg_q == $past(snap_q) && sts_q[`CQTS_IRQ_LOAD])
        else $error("load did not restore the snapshot");

    a_trig_pos_legal: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        cfg_q.trig_pos != `CQTS_TRIG_POS_BAD)
        else $error("illegal trigger position stored");

    a_wiring_code_legal: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        cfg_q.wiring[0] <= `CQTS_WIRING_MAX && cfg_q.wiring[1] <= `CQTS_WIRING_MAX
        && cfg_q.wiring[2] <= `CQTS_WIRING_MAX)
        else $error("illegal wiring code stored");

    a_trq_src_legal: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        cfg_q.trq_src <= `CQTS_TRQ_SRC_MAX)
        else $error("illegal torque source stored");

    a_voltage_scaling_query_off_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        s_cmd(4'h7) and pwdata[7:4] == 4'h2 and !cfg_q.scale_en[1] |=> value_q == 32'h0)
        else $error("disabled scaling did not read as zero");

    a_apb_answer_once: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("access phase not answered in one wait state");

endmodule

// [testbench/cqts_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// remote host: apb master issuing commands and reading answers
// ----------------------------------------------------------------
module cqts_host_model (
    input wire logic pclk,
    input wire logic presetn,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    int hangs = 0;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer; released lines show inverted data so stale values never match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            hangs++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// [testbench/cqts_top_tb.sv]
`timescale 1ns/1ps
`include "cqts_defines.svh"
module cqts_top_tb;
    import cqts_pkg::*;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    logic last_err;
    logic [31:0] f;
    logic [31:0] v;
    int failures = 0;
    int checks_done = 0;

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    cqts_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq));

    cqts_host_model host_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // ----------------------------------------------------------------
    // report, compare and bus tasks
    // ----------------------------------------------------------------
    task stop_test;
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task rd(input logic [7:0] a, output logic [31:0] q);
        host_u.xfer(1'b0, a, 32'h0, q, last_err);
        if (host_u.hangs != 0)
        begin
            failures++;
            stop_test;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host_u.xfer(1'b1, a, d, q, last_err);
        if (host_u.hangs != 0)
        begin
            failures++;
            stop_test;
        end
    endtask

    task query(input cqts_op_t op, input logic [3:0] idx);
        wr(`CQTS_OFS_CMD, {24'h0, idx, op});
        rd(`CQTS_OFS_RESP_FIELDS, f);
        rd(`CQTS_OFS_RESP_VALUE, v);
    endtask

    // irq is registered from the next status and mask, so it changes on the same edge as they do; wait two edges
    task chk_irq(input logic exp);
        repeat (2) @(posedge pclk);
        #1 chk_bit(irq, exp);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CQTS_OFS_STATUS, f);
        chk_word(f, 32'h0);
        wr(`CQTS_OFS_TRIG_CFG, 32'h337);
        wr(`CQTS_OFS_TRIG_LEVEL, 32'h40A00000);
        query(CQTS_OP_Q_TRIG, 4'h0);
        chk_word(f, 32'h337);
        chk_word(v, 32'h40A00000);
        chk_irq(1'b0);
        for (int i = 0; i < 8; i++)
        begin
            wr(`CQTS_OFS_TRIG_CFG, 32'h100 | (i << 4 & 32'h30) | i);
            query(CQTS_OP_Q_TRIG, 4'h0);
            chk_word(f, 32'h100 | (i << 4 & 32'h30) | i);
        end
        wr(`CQTS_OFS_TRIG_CFG, 32'h337);
        wr(`CQTS_OFS_TRIG_CFG, 32'h201);
        query(CQTS_OP_Q_TRIG, 4'h0);
        chk_word(f, 32'h337);
        wr(`CQTS_OFS_IRQ_MASK, 32'h1F);
        chk_irq(1'b1);
        rd(`CQTS_OFS_IRQ_STS, f);
        chk_word(f, 32'h18);
        chk_irq(1'b0);
        for (int s = 0; s < 3; s++)
        begin
            wr(`CQTS_OFS_TRQ_SRC, s);
            query(CQTS_OP_Q_TRQ_SRC, 4'h0);
            chk_word(f, s);
        end
        wr(`CQTS_OFS_TRQ_SRC, 32'h3);
        query(CQTS_OP_Q_TRQ_SRC, 4'h0);
        chk_word(f, 32'h2);
        wr(`CQTS_OFS_TRQ_OFFSET, 32'h3F800000);
        wr(`CQTS_OFS_TRQ_SCALE, 32'hC0000000);
        query(CQTS_OP_Q_TRQ_OFF, 4'h0);
        chk_word(v, 32'h3F800000);
        query(CQTS_OP_Q_TRQ_SCALE, 4'h0);
        chk_word(v, 32'hC0000000);
        wr(`CQTS_OFS_SCALE_EN, 32'h5);
        for (int c = 1; c <= 4; c++)
        begin
            wr(`CQTS_OFS_VSCALE0 + 8'(4 * (c - 1)), 32'h41000000 + c);
            query(CQTS_OP_Q_VOLTAGE_SCALING_QUERY, 4'(c));
            chk_word(v, (c % 2 == 1) ? 32'h41000000 + c : 32'h0);
        end
        rd(`CQTS_OFS_VSCALE0 + 8'h4, f);
        chk_word(f, 32'h41000002);
        chk_bit(last_err, 1'b0);
        wr(`CQTS_OFS_GROUP_MAP, 32'h39);
        for (int c = 1; c <= 4; c++)
        begin
            query(CQTS_OP_Q_GROUP, 4'(c));
            chk_word(f, (32'h39 >> (2 * (c - 1))) & 32'h3);
        end
        for (int c = 0; c < 5; c++)
        begin
            wr(`CQTS_OFS_WIRING, c | (c << 3) | (c << 6));
            query(CQTS_OP_Q_WIRING, 4'(c % 3 + 1));
            chk_word(f, c);
        end
        wr(`CQTS_OFS_WIRING, 32'h5);
        query(CQTS_OP_Q_WIRING, 4'h1);
        chk_word(f, 32'h4);
        rd(`CQTS_OFS_IRQ_STS, f);
        // snapshot: load before save, save, load, then a second load
        wr(`CQTS_OFS_CMD, CQTS_OP_LOAD);
        rd(`CQTS_OFS_IRQ_STS, f);
        chk_word(f, 32'h4);
        wr(`CQTS_OFS_CMD, CQTS_OP_SAVE);
        rd(`CQTS_OFS_STATUS, f);
        chk_word(f, 32'h1);
        wr(`CQTS_OFS_TRQ_SRC, 32'h1);
        wr(`CQTS_OFS_TRIG_CFG, 32'h0);
        wr(`CQTS_OFS_CMD, CQTS_OP_LOAD);
        rd(`CQTS_OFS_TRQ_SRC, f);
        chk_word(f, 32'h2);
        rd(`CQTS_OFS_TRIG_CFG, f);
        chk_word(f, 32'h337);
        rd(`CQTS_OFS_STATUS, f);
        chk_word(f, 32'h0);
        rd(`CQTS_OFS_IRQ_STS, f);
        chk_word(f, 32'h3);
        wr(`CQTS_OFS_TRQ_SRC, 32'h1);
        wr(`CQTS_OFS_CMD, CQTS_OP_LOAD);
        rd(`CQTS_OFS_IRQ_STS, f);
        chk_word(f, 32'h4);
        rd(`CQTS_OFS_TRQ_SRC, f);
        chk_word(f, 32'h1);
        wr(`CQTS_OFS_CMD, 32'hF);
        rd(`CQTS_OFS_IRQ_STS, f);
        chk_word(f, 32'h10);
        rd(`CQTS_OFS_CMD, f);
        chk_word(f, 32'h0);
        chk_bit(last_err, 1'b0);
        rd(8'h3C, f);
        chk_bit(last_err, 1'b1);
        query(CQTS_OP_Q_WIRING, 4'h4);
        chk_word(f, 32'h4);
        rd(`CQTS_OFS_IRQ_STS, f);
        chk_word(f, 32'h10);
        // a reset in mid-run drops the snapshot
        wr(`CQTS_OFS_CMD, CQTS_OP_SAVE);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`CQTS_OFS_STATUS, f);
        chk_word(f, 32'h0);
        wr(`CQTS_OFS_CMD, CQTS_OP_LOAD);
        rd(`CQTS_OFS_IRQ_STS, f);
        chk_word(f, 32'h4);
        stop_test;
    end
endmodule
